// [serial_port_defines.svh]
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// ****************************************
// global control word
// ****************************************
`define GCR_MASTER_BIT 0
`define GCR_ENABLE_BIT 1

// ****************************************
// word format word
// ****************************************
`define FMT_LEN_MSB 4
`define FMT_LEN_LSB 0
`define FMT_PS_MSB 15
`define FMT_PS_LSB 8
`define FMT_PHASE_BIT 16
`define FMT_POL_BIT 17

// ****************************************
// select delay word
// ****************************************
`define DLY_SETUP_MSB 31
`define DLY_SETUP_LSB 24
`define DLY_HOLD_MSB 23
`define DLY_HOLD_LSB 16

// ****************************************
// buffer entry layout
// ****************************************
`define ENT_TX_MSB 15
`define ENT_TX_LSB 0
`define ENT_RX_MSB 31
`define ENT_RX_LSB 16
`define ENT_CTRL_MSB 47
`define ENT_CTRL_LSB 32
`define ENT_STAT_MSB 63
`define ENT_STAT_LSB 48
`define CTRL_KEEP_BIT 12
`define CTRL_FSEL_MSB 9
`define CTRL_FSEL_LSB 8
`define STAT_DONE_BIT 0
`define STAT_ABORT_BIT 1
`define STAT_RESET 16'h0000

// ****************************************
// word length and timing
// ****************************************
`define MIN_WORD_LEN 5'h02
`define MAX_WORD_LEN 5'h10
`define PS_ZERO_PERIOD 9'h002
`define SETUP_EXTRA 9'h001
`define KEEP_EXTRA 9'h001
`define CLK_PERIOD_NS 8
`define MIN_SCLK_PERIOD_NS 25
`define MIN_SCLK_CYC ((`MIN_SCLK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// pin indices
// ****************************************
`define PIN_SCLK 0
`define PIN_MOSI 1
`define PIN_MISO 2
`define PIN_CS 3

`endif

// [serial_port_pkg.sv]
package serial_port_pkg;

  // gray codes along idle-fetch-load-setup-shift-hold-store
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_LOAD = 3'h3,
    ST_SETUP = 3'h2,
    ST_SHIFT = 3'h6,
    ST_HOLD = 3'h7,
    ST_STORE = 3'h5
  } state_t;

endpackage

// [buffer_ram.sv]
`timescale 1ns/1ps
`default_nettype none

module buffer_ram #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 64,
  parameter int AW = 8
) (
  // clock
  input wire logic clk,
  // software port
  input wire logic [AW-1:0] a_addr,
  input wire logic a_wr,
  input wire logic [WIDTH-1:0] a_wdata,
  output logic [WIDTH-1:0] a_rdata,
  // engine port
  input wire logic [AW-1:0] b_addr,
  input wire logic b_wr,
  input wire logic [WIDTH-1:0] b_wdata,
  output logic [WIDTH-1:0] b_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // engine write wins a same-address collision
  always_ff @(posedge clk) begin
    if (a_wr && !(b_wr && b_addr == a_addr)) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_wr) begin
      mem[b_addr] <= b_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule

`default_nettype wire

// [multibuffered_serial_port.sv]
`include "serial_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module multibuffered_serial_port #(
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter int NUM_GROUPS = 4,
  parameter int NUM_FORMATS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration words
  input wire logic [31:0] global_control_reg,
  input wire logic [NUM_FORMATS-1:0][31:0] word_format_reg,
  input wire logic [31:0] select_delay_reg,
  // transfer groups
  input wire logic [NUM_GROUPS-1:0][AW-1:0] group_first,
  input wire logic [NUM_GROUPS-1:0][AW-1:0] group_last,
  input wire logic [NUM_GROUPS-1:0] group_trigger,
  output logic [NUM_GROUPS-1:0] group_done_q,
  // software buffer port
  input wire logic [AW-1:0] buf_addr,
  input wire logic buf_wr,
  input wire logic [63:0] buf_wdata,
  output logic [63:0] buf_rdata,
  // status
  output logic busy_q,
  output logic [15:0] rx_buffer_q,
  output logic rx_valid_q,
  output logic rate_violation_q,
  // general-purpose use of pins
  input wire logic [3:0] gpio_enable,
  input wire logic [3:0] gpio_dir,
  input wire logic [3:0] gpio_out,
  output logic [3:0] gpio_in_q,
  // pins
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic master_out_data_pin_i,
  output logic master_out_data_pin_o,
  output logic master_out_data_pin_oe,
  input wire logic master_in_data_pin_i,
  output logic master_in_data_pin_o,
  output logic master_in_data_pin_oe,
  input wire logic chip_select_n_pin_i,
  output logic chip_select_n_pin_o,
  output logic chip_select_n_pin_oe
);

  // ****************************************
  // declarations
  // ****************************************
  serial_port_pkg::state_t state_q;
  logic [3:0] pin_in, sync1_q, sync2_q;
  logic sclk_s3_q;
  logic [3:0] pin_o_q, pin_oe_q, func_o, func_oe;
  logic [NUM_GROUPS-1:0] pending_q, accept;
  logic any_pending;
  logic [AW-1:0] pick_first, pick_last;
  logic [AW-1:0] entry_q, last_q;
  logic [NUM_GROUPS-1:0] group_q;
  logic [63:0] eng_rdata, eng_wdata;
  logic eng_wr;
  logic [31:0] fmt_w, fmt_q;
  logic [15:0] tx_q, ctrl_q, rx_q, ctrl_w;
  logic [16:0] sh_q;
  logic [4:0] len_w, len_q;
  logic [7:0] ps;
  logic [8:0] per, half_lo, half_hi, cnt_q;
  logic [5:0] edge_cnt_q;
  logic sclk_q, cs_q, abort_q;
  logic master, enable, keep, phase, polarity;
  logic edge_now, lead, last_edge, slave_sel;
  logic [15:0] aligned;

  assign master = global_control_reg[`GCR_MASTER_BIT];
  assign enable = global_control_reg[`GCR_ENABLE_BIT];
  assign keep = ctrl_q[`CTRL_KEEP_BIT];
  assign phase = fmt_q[`FMT_PHASE_BIT];
  assign polarity = fmt_q[`FMT_POL_BIT];

  // ****************************************
  // pin synchronisers
  // ****************************************
  assign pin_in = {chip_select_n_pin_i, master_in_data_pin_i,
                   master_out_data_pin_i, serial_clock_pin_i};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // idle levels: select high, clock and data low, so no false edge
      sync1_q <= 4'h8;
      sync2_q <= 4'h8;
      sclk_s3_q <= 1'b0;
      gpio_in_q <= 4'h0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sclk_s3_q <= sync2_q[`PIN_SCLK];
      gpio_in_q <= sync2_q;
    end
  end

  assign slave_sel = !sync2_q[`PIN_CS];

  // ****************************************
  // transfer groups
  // ****************************************
  always_comb begin
    accept = '0;
    pick_first = '0;
    pick_last = '0;
    any_pending = 1'b0;
    for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
      if (pending_q[g]) begin
        any_pending = 1'b1;
        accept = '0;
        accept[g] = 1'b1;
        pick_first = group_first[g];
        pick_last = group_last[g];
      end
    end
    if (!(state_q == serial_port_pkg::ST_IDLE && enable)) begin
      accept = '0;
    end
  end

  // a trigger in the accepting cycle stays pending
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_pend
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pending_q[gi] <= 1'b0;
        end else begin
          pending_q[gi] <= group_trigger[gi] | (pending_q[gi] & ~accept[gi]);
        end
      end
    end
  endgenerate

  // ****************************************
  // word format decode
  // ****************************************
  always_comb begin
    ctrl_w = eng_rdata[`ENT_CTRL_MSB:`ENT_CTRL_LSB];
    fmt_w = word_format_reg[ctrl_w[`CTRL_FSEL_MSB:`CTRL_FSEL_LSB]];
    len_w = fmt_w[`FMT_LEN_MSB:`FMT_LEN_LSB];
    if (len_w < `MIN_WORD_LEN || len_w > `MAX_WORD_LEN) begin
      len_w = (len_w == 5'h00) ? `MAX_WORD_LEN : `MIN_WORD_LEN;
    end
    aligned = eng_rdata[`ENT_TX_MSB:`ENT_TX_LSB] << (`MAX_WORD_LEN - len_w);
  end

  assign ps = fmt_q[`FMT_PS_MSB:`FMT_PS_LSB];
  assign per = (ps == 8'h00) ? `PS_ZERO_PERIOD : {1'b0, ps} + 9'h001;
  assign half_lo = per >> 1;
  assign half_hi = per - half_lo;

  // ****************************************
  // edge generation
  // ****************************************
  assign lead = !edge_cnt_q[0];
  assign last_edge = ({edge_cnt_q + 6'h01} == {len_q, 1'b0});

  always_comb begin
    edge_now = 1'b0;
    if (master) begin
      edge_now = (cnt_q == 9'h000) &&
                 (state_q == serial_port_pkg::ST_SETUP || state_q == serial_port_pkg::ST_SHIFT);
    end else if (state_q == serial_port_pkg::ST_SHIFT) begin
      edge_now = (sync2_q[`PIN_SCLK] != sclk_s3_q);
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= serial_port_pkg::ST_IDLE;
      entry_q <= '0;
      last_q <= '0;
      group_q <= '0;
      cnt_q <= 9'h000;
      cs_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      case (state_q)
        serial_port_pkg::ST_IDLE: begin
          if (enable && any_pending) begin
            entry_q <= pick_first;
            last_q <= pick_last;
            group_q <= accept;
            state_q <= serial_port_pkg::ST_FETCH;
          end
        end
        serial_port_pkg::ST_FETCH: begin
          state_q <= serial_port_pkg::ST_LOAD;
        end
        serial_port_pkg::ST_LOAD: begin
          abort_q <= 1'b0;
          if (master) begin
            cs_q <= 1'b1;
            cnt_q <= {1'b0, select_delay_reg[`DLY_SETUP_MSB:`DLY_SETUP_LSB]}
                     + `SETUP_EXTRA
                     + (eng_rdata[`CTRL_KEEP_BIT + `ENT_CTRL_LSB] ? `KEEP_EXTRA : 9'h000);
          end
          state_q <= serial_port_pkg::ST_SETUP;
        end
        serial_port_pkg::ST_SETUP: begin
          if (master) begin
            if (cnt_q == 9'h000) begin
              cnt_q <= half_hi - 9'h001;
              state_q <= serial_port_pkg::ST_SHIFT;
            end else begin
              cnt_q <= cnt_q - 9'h001;
            end
          end else if (slave_sel) begin
            state_q <= serial_port_pkg::ST_SHIFT;
          end
        end
        serial_port_pkg::ST_SHIFT: begin
          if (master) begin
            if (edge_now && last_edge) begin
              cnt_q <= half_lo + {1'b0, select_delay_reg[`DLY_HOLD_MSB:`DLY_HOLD_LSB]};
              state_q <= serial_port_pkg::ST_HOLD;
            end else if (edge_now) begin
              cnt_q <= (lead ? half_hi : half_lo) - 9'h001;
            end else begin
              cnt_q <= cnt_q - 9'h001;
            end
          end else if (!slave_sel) begin
            abort_q <= 1'b1;
            state_q <= serial_port_pkg::ST_STORE;
          end else if (edge_now && last_edge) begin
            state_q <= serial_port_pkg::ST_STORE;
          end
        end
        serial_port_pkg::ST_HOLD: begin
          if (cnt_q == 9'h000) begin
            state_q <= serial_port_pkg::ST_STORE;
          end else begin
            cnt_q <= cnt_q - 9'h001;
          end
        end
        serial_port_pkg::ST_STORE: begin
          if (!keep) begin
            cs_q <= 1'b0;
          end
          if (entry_q == last_q) begin
            state_q <= serial_port_pkg::ST_IDLE;
          end else begin
            entry_q <= entry_q + 1'b1;
            state_q <= serial_port_pkg::ST_FETCH;
          end
        end
        default: begin
          state_q <= serial_port_pkg::ST_IDLE;
          cs_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // shift datapath
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= 17'h00000;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      ctrl_q <= 16'h0000;
      fmt_q <= 32'h00000000;
      len_q <= `MIN_WORD_LEN;
      edge_cnt_q <= 6'h00;
      sclk_q <= 1'b0;
    end else if (state_q == serial_port_pkg::ST_LOAD) begin
      tx_q <= eng_rdata[`ENT_TX_MSB:`ENT_TX_LSB];
      ctrl_q <= eng_rdata[`ENT_CTRL_MSB:`ENT_CTRL_LSB];
      fmt_q <= fmt_w;
      len_q <= len_w;
      rx_q <= 16'h0000;
      edge_cnt_q <= 6'h00;
      sclk_q <= 1'b0;
      // phase 0 puts the first bit out now, phase 1 on the first edge
      sh_q <= fmt_w[`FMT_PHASE_BIT] ? {1'b0, aligned} : {aligned, 1'b0};
    end else if (edge_now) begin
      edge_cnt_q <= edge_cnt_q + 6'h01;
      sclk_q <= !sclk_q;
      if (lead ^ phase) begin
        // slow sampling: the in-data path has the two-stage sync delay
        rx_q <= {rx_q[14:0], master ? sync2_q[`PIN_MISO] : sync2_q[`PIN_MOSI]};
      end else begin
        sh_q <= {sh_q[15:0], 1'b0};
      end
    end
  end

  // ****************************************
  // receive store
  // ****************************************
  assign eng_wr = (state_q == serial_port_pkg::ST_STORE);

  always_comb begin
    eng_wdata = {`STAT_RESET, ctrl_q, rx_q, tx_q};
    eng_wdata[`STAT_DONE_BIT + `ENT_STAT_LSB] = 1'b1;
    eng_wdata[`STAT_ABORT_BIT + `ENT_STAT_LSB] = abort_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_buffer_q <= 16'h0000;
      rx_valid_q <= 1'b0;
      group_done_q <= '0;
      busy_q <= 1'b0;
      rate_violation_q <= 1'b0;
    end else begin
      rx_valid_q <= eng_wr;
      group_done_q <= (eng_wr && entry_q == last_q) ? group_q : '0;
      busy_q <= (state_q != serial_port_pkg::ST_IDLE);
      if (eng_wr) begin
        rx_buffer_q <= rx_q;
      end
      if (state_q == serial_port_pkg::ST_SETUP && master) begin
        // flags a word whose bit period is under the 25 ns floor
        rate_violation_q <= (per < 9'(`MIN_SCLK_CYC));
      end
    end
  end

  buffer_ram #(
    .DEPTH(DEPTH),
    .WIDTH(64),
    .AW(AW)
  ) u_ram (
    .clk(clk),
    .a_addr(buf_addr),
    .a_wr(buf_wr),
    .a_wdata(buf_wdata),
    .a_rdata(buf_rdata),
    .b_addr(entry_q),
    .b_wr(eng_wr),
    .b_wdata(eng_wdata),
    .b_rdata(eng_rdata)
  );

  // ****************************************
  // pin drivers
  // ****************************************
  always_comb begin
    func_o = 4'h0;
    func_oe = 4'h0;
    if (master) begin
      func_o[`PIN_SCLK] = sclk_q ^ polarity;
      func_o[`PIN_MOSI] = sh_q[16];
      func_o[`PIN_CS] = !cs_q;
      func_oe[`PIN_SCLK] = 1'b1;
      func_oe[`PIN_MOSI] = 1'b1;
      func_oe[`PIN_CS] = 1'b1;
    end else begin
      func_o[`PIN_MISO] = sh_q[16];
      func_oe[`PIN_MISO] = slave_sel && state_q != serial_port_pkg::ST_IDLE;
    end
  end

  genvar pi;
  generate
    for (pi = 0; pi < 4; pi++) begin : g_pin
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pin_o_q[pi] <= 1'b0;
          pin_oe_q[pi] <= 1'b0;
        end else if (gpio_enable[pi]) begin
          pin_o_q[pi] <= gpio_out[pi];
          pin_oe_q[pi] <= gpio_dir[pi];
        end else begin
          pin_o_q[pi] <= func_o[pi];
          pin_oe_q[pi] <= func_oe[pi];
        end
      end
    end
  endgenerate

  assign serial_clock_pin_o = pin_o_q[`PIN_SCLK];
  assign serial_clock_pin_oe = pin_oe_q[`PIN_SCLK];
  assign master_out_data_pin_o = pin_o_q[`PIN_MOSI];
  assign master_out_data_pin_oe = pin_oe_q[`PIN_MOSI];
  assign master_in_data_pin_o = pin_o_q[`PIN_MISO];
  assign master_in_data_pin_oe = pin_oe_q[`PIN_MISO];
  assign chip_select_n_pin_o = pin_o_q[`PIN_CS];
  assign chip_select_n_pin_oe = pin_oe_q[`PIN_CS];

endmodule

`default_nettype wire

// [serial_port_chk.sv]
`include "serial_port_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// ****
// port checker
// ****
module serial_port_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire logic [31:0] global_control_reg,
  input wire logic [31:0] select_delay_reg,
  input wire logic [3:0] gpio_enable,
  input wire logic [3:0] gpio_dir,
  input wire logic [3:0] gpio_out,
  // status
  input wire logic [3:0] group_done_q,
  input wire logic [15:0] rx_buffer_q,
  input wire logic rx_valid_q,
  // pins
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic master_out_data_pin_oe,
  input wire logic master_in_data_pin_oe,
  input wire logic chip_select_n_pin_o,
  input wire logic chip_select_n_pin_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic [8:0] since_fall_q;
  logic first_q;
  logic cs_prev_q;
  logic sclk_prev_q;
  logic [8:0] setup_cnt;
  assign setup_cnt = {1'b0, select_delay_reg[`DLY_SETUP_MSB:`DLY_SETUP_LSB]};

  // counts from select falling and keeps counting; first_q marks the first clock edge only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_fall_q <= 9'h000;
      first_q <= 1'b0;
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= chip_select_n_pin_o;
      sclk_prev_q <= serial_clock_pin_o;
      if (cs_prev_q && !chip_select_n_pin_o) begin
        since_fall_q <= 9'h001;
        first_q <= 1'b1;
      end else begin
        since_fall_q <= since_fall_q + 9'h001;
        if (serial_clock_pin_o != sclk_prev_q) begin
          first_q <= 1'b0;
        end
      end
    end
  end

  master_pins_a: assert property (
    global_control_reg[`GCR_MASTER_BIT] && gpio_enable == 4'h0 |=>
      serial_clock_pin_oe && master_out_data_pin_oe && !master_in_data_pin_oe)
    else $error("master pin directions wrong");
  slave_pins_a: assert property (
    !global_control_reg[`GCR_MASTER_BIT] && gpio_enable == 4'h0 |=>
      !serial_clock_pin_oe && !master_out_data_pin_oe)
    else $error("slave drives clock or out-data");
  setup_delay_a: assert property (
    first_q && serial_clock_pin_o != sclk_prev_q |->
      since_fall_q == setup_cnt + 9'h002 || since_fall_q == setup_cnt + 9'h003)
    else $error("select to first edge delay wrong");
  rx_update_a: assert property ($changed(rx_buffer_q) |-> rx_valid_q)
    else $error("receive word changed without valid");
  rx_pulse_a: assert property (rx_valid_q |=> !rx_valid_q)
    else $error("receive valid longer than one cycle");
  done_pulse_a: assert property (group_done_q != 4'h0 |=> group_done_q == 4'h0)
    else $error("group done longer than one cycle");
  gpio_drive_a: assert property (
    gpio_enable[`PIN_CS] && gpio_dir[`PIN_CS] |=>
      chip_select_n_pin_oe && chip_select_n_pin_o == $past(gpio_out[`PIN_CS]))
    else $error("general output not driven");
  gpio_float_a: assert property (
    gpio_enable[`PIN_CS] && !gpio_dir[`PIN_CS] |=> !chip_select_n_pin_oe)
    else $error("general input still driven");
endmodule

`default_nettype wire

// [serial_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****
// external slave
// ****
module serial_slave_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // word setup
  input wire logic cpha,
  input wire logic [4:0] len,
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word
);
  logic sclk_q;
  logic cs_q;
  logic [3:0] idx;
  logic [5:0] edges;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      idx <= 4'h0;
      edges <= 6'h00;
      miso <= 1'b0;
      rx_word <= 16'h0000;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      if (cs_n) begin
        // released line: a value that moves every cycle
        miso <= ~miso;
      end else if (cs_q || edges == {len, 1'b0}) begin
        // reload also at word end, select may stay low into the next word
        edges <= 6'h00;
        if (!cpha) begin
          miso <= tx_word[4'(len - 5'h01)];
          idx <= 4'(len - 5'h02);
        end else begin
          idx <= 4'(len - 5'h01);
        end
      end else if (sclk != sclk_q) begin
        edges <= edges + 6'h01;
        if (~edges[0] ^ cpha) begin
          rx_word <= {rx_word[14:0], mosi};
        end else begin
          miso <= tx_word[idx];
          idx <= idx - 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none

// ****
// stimulus and checks
// ****
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] global_control_reg = 32'h00000002;
  logic [3:0][31:0] word_format_reg = '0;
  logic [31:0] select_delay_reg = 32'h03020000;
  logic [3:0][7:0] group_first = 32'h03020100;
  logic [3:0][7:0] group_last = 32'h03020100;
  logic [3:0] group_trigger = 4'h0;
  logic [3:0] group_done_q, gpio_in_q;
  logic [7:0] buf_addr = 8'h00;
  logic buf_wr = 1'b0;
  logic [63:0] buf_wdata = '0;
  logic [63:0] buf_rdata, e;
  logic busy_q, rx_valid_q, rate_violation_q;
  logic [15:0] rx_buffer_q, s_rx;
  logic [3:0] gpio_enable = 4'h0, gpio_dir = 4'h0, gpio_out = 4'h0;
  logic serial_clock_pin_o, serial_clock_pin_oe, master_out_data_pin_o;
  logic master_out_data_pin_oe, master_in_data_pin_o, master_in_data_pin_oe;
  logic chip_select_n_pin_o, chip_select_n_pin_oe, miso_m;
  logic cpha = 1'b0;
  logic [4:0] s_len = 5'h08;
  logic [15:0] s_tx = 16'h0000;
  logic sck_drv = 1'b0, cs_drv = 1'b1, mosi_drv = 1'b0;
  // undriven pins take the bench's own drive (clock and out-data low, select high); in-data takes the slave model
  wire logic serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o : sck_drv;
  wire logic master_out_data_pin_i = master_out_data_pin_oe ? master_out_data_pin_o : mosi_drv;
  wire logic master_in_data_pin_i = master_in_data_pin_oe ? master_in_data_pin_o : miso_m;
  wire logic chip_select_n_pin_i = chip_select_n_pin_oe ? chip_select_n_pin_o : cs_drv;
  int error_cnt = 0, compares = 0, cyc = 0, t_fall = 0, t_e1 = 0, t_last = 0;
  int n_edge = 0, n_rise = 0, setup_c = 0, per_c = 0, hold_c = 0, r0;
  logic cs_p = 1'b1, sck_p = 1'b0;
  int lens[4] = '{8, 16, 2, 5};
  // half periods of 4 or more: sampled in-data passes the two-stage sync
  int pss[4] = '{9, 9, 9, 8};
  int phs[4] = '{0, 1, 0, 1};
  int pols[4] = '{0, 1, 1, 0};
  int rps[3] = '{255, 3, 0};
  logic [15:0] txw[4] = '{16'h00A5, 16'hC3E1, 16'h0002, 16'h0013};
  logic [15:0] sw[4] = '{16'h003C, 16'h5A96, 16'h0001, 16'h000A};
  logic [15:0] m;

  always #4 clk = ~clk;

  multibuffered_serial_port dut (.clk, .rstn, .global_control_reg, .word_format_reg,
    .select_delay_reg, .group_first, .group_last, .group_trigger, .group_done_q,
    .buf_addr, .buf_wr, .buf_wdata, .buf_rdata, .busy_q, .rx_buffer_q, .rx_valid_q,
    .rate_violation_q, .gpio_enable, .gpio_dir, .gpio_out, .gpio_in_q,
    .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe,
    .master_out_data_pin_i, .master_out_data_pin_o, .master_out_data_pin_oe,
    .master_in_data_pin_i, .master_in_data_pin_o, .master_in_data_pin_oe,
    .chip_select_n_pin_i, .chip_select_n_pin_o, .chip_select_n_pin_oe);

  serial_slave_model slave (.clk, .rstn, .sclk(serial_clock_pin_i),
    .cs_n(chip_select_n_pin_i), .mosi(master_out_data_pin_i), .miso(miso_m),
    .cpha, .len(s_len), .tx_word(s_tx), .rx_word(s_rx));

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr_entry(logic [7:0] a, logic [15:0] ctrl, logic [15:0] tx);
    @(posedge clk);
    buf_addr <= a;
    buf_wr <= 1'b1;
    buf_wdata <= {16'h0000, ctrl, 16'h0000, tx};
    @(posedge clk);
    buf_wr <= 1'b0;
  endtask

  task automatic rd_entry(logic [7:0] a);
    @(posedge clk);
    buf_addr <= a;
    repeat (2) @(posedge clk);
    e = buf_rdata;
  endtask

  task automatic run(int g);
    int n;
    n = 0;
    @(posedge clk);
    group_trigger[g] <= 1'b1;
    @(posedge clk);
    group_trigger <= 4'h0;
    repeat (3) @(posedge clk);
    check("busy", busy_q, 1);
    while (group_done_q[g] !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    check("group done", n < 9000, 1);
    repeat (4) @(posedge clk);
    check("idle busy", busy_q, 0);
  endtask

  // link timing seen at the pins, in clock cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cs_p && !chip_select_n_pin_i) begin
      t_fall = cyc;
      n_edge = 0;
    end
    // a polarity change lands with the select fall and is no clock edge
    if (!cs_p && !chip_select_n_pin_i && serial_clock_pin_o != sck_p) begin
      n_edge = n_edge + 1;
      t_last = cyc;
      if (n_edge == 1) setup_c = cyc - t_fall;
      if (n_edge == 1) t_e1 = cyc;
      if (n_edge == 3) per_c = cyc - t_e1;
    end
    if (!cs_p && chip_select_n_pin_i) begin
      n_rise = n_rise + 1;
      hold_c = cyc - t_last;
    end
    cs_p = chip_select_n_pin_i;
    sck_p = serial_clock_pin_o;
    if (cyc > 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    for (int i = 0; i < 4; i++) begin
      word_format_reg[i] = {14'h0, 1'(pols[i]), 1'(phs[i]), 8'(pss[i]), 3'h0, 5'(lens[i] % 16)};
    end
    repeat (2) @(posedge clk);
    check("reset oe", {serial_clock_pin_oe, master_out_data_pin_oe, chip_select_n_pin_oe}, 0);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    check("slave clock oe", serial_clock_pin_oe, 0);
    global_control_reg <= 32'h00000003;
    repeat (3) @(posedge clk);
    check("master oe", {serial_clock_pin_oe, master_out_data_pin_oe, master_in_data_pin_oe}, 6);
    for (int i = 0; i < 4; i++) begin
      m = 16'((32'h1 << lens[i]) - 1);
      cpha <= 1'(phs[i]);
      s_len <= 5'(lens[i]);
      s_tx <= sw[i];
      wr_entry(8'(i), 16'(i) << 8, txw[i]);
      run(i);
      check("slave rx", s_rx & m, txw[i] & m);
      check("rx buffer", rx_buffer_q, sw[i] & m);
      check("setup", setup_c, 5);
      check("period", per_c, pss[i] + 1);
      check("hold", hold_c, (pss[i] + 1) / 2 + 4);
      check("idle clock", serial_clock_pin_o, pols[i]);
      rd_entry(8'(i));
      check("entry rx", e[31:16], sw[i] & m);
      check("entry done", e[48], 1);
      $display("test word %0d finished", i);
    end
    cpha <= 1'b0;
    s_len <= 5'h08;
    s_tx <= 16'h0042;
    group_first[0] <= 8'h04;
    group_last[0] <= 8'h05;
    wr_entry(8'h04, 16'h1000, 16'h0081);
    wr_entry(8'h05, 16'h0000, 16'h0081);
    r0 = n_rise;
    run(0);
    check("select releases", n_rise - r0, 1);
    check("keep setup", setup_c, 6);
    check("slave rx pair", s_rx, 16'h8181);
    rd_entry(8'h05);
    check("entry rx", e[31:16], 16'h0042);
    $display("test keep finished");
    group_first[0] <= 8'h00;
    group_last[0] <= 8'h00;
    for (int j = 0; j < 3; j++) begin
      word_format_reg[0][15:8] <= 8'(rps[j]);
      run(0);
      check("rate period", per_c, (rps[j] == 0) ? 2 : rps[j] + 1);
      check("rate flag", rate_violation_q, rps[j] == 0);
    end
    $display("test rate finished");
    global_control_reg <= 32'h00000002;
    fork
      run(0);
      begin
        repeat (8) @(posedge clk);
        cs_drv <= 1'b0;
        for (int b = 7; b >= 0; b--) begin
          repeat (6) @(posedge clk);
          mosi_drv <= 1'(8'hC5 >> b);
          repeat (6) @(posedge clk);
          sck_drv <= 1'b1;
          repeat (6) @(posedge clk);
          sck_drv <= 1'b0;
        end
        repeat (6) @(posedge clk);
        cs_drv <= 1'b1;
      end
    join
    check("slave word", rx_buffer_q, 16'h00C5);
    $display("test slave finished");
    gpio_enable[3] <= 1'b1;
    gpio_dir[3] <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      gpio_out[3] <= 1'(k);
      repeat (5) @(posedge clk);
      check("gp out", chip_select_n_pin_i, k);
      check("gp in", gpio_in_q[3], k);
    end
    gpio_dir[3] <= 1'b0;
    repeat (5) @(posedge clk);
    check("gp float", chip_select_n_pin_oe, 0);
    $display("test pins finished");
    give_verdict();
  end
endmodule

bind multibuffered_serial_port serial_port_chk chk (.clk, .rstn, .global_control_reg,
  .select_delay_reg, .gpio_enable, .gpio_dir, .gpio_out, .group_done_q, .rx_buffer_q,
  .rx_valid_q, .serial_clock_pin_o, .serial_clock_pin_oe, .master_out_data_pin_oe,
  .master_in_data_pin_oe, .chip_select_n_pin_o, .chip_select_n_pin_oe);

`default_nettype wire
